// ---- hw/miau_defines.vh ----
/*
  constant definitions for the maskable interrupt accept unit:
  register addresses, field positions, reset values and timing counts.
  assumes inclusion by bare name from the design file.
*/
`ifndef MIAU_DEFINES_VH
`define MIAU_DEFINES_VH

// register addresses in the 8-bit special-function space
`define MIAU_ADDR_EN_EXT 8'h2C
`define MIAU_ADDR_RL_EXT 8'h2E
`define MIAU_ADDR_EN_LOW 8'h3A
`define MIAU_ADDR_EN_HIGH 8'h3B
`define MIAU_ADDR_RL_LOW 8'h3C
`define MIAU_ADDR_RL_HIGH 8'h3D

// field positions
`define MIAU_GIE_BIT 0
`define MIAU_FIRST_MASKABLE 4
`define MIAU_NUM_SRC 24

// reset values
`define MIAU_EN_RESET 24'h000000
`define MIAU_RL_RESET 24'h000000
`define MIAU_RL_BIT_RESET 1'b0

// vector slot bases: sources below 16 count down from the first base,
// sources 16 and up from the second, lower one
`define MIAU_VEC_BASE_LOW 16'hFFFE
`define MIAU_VEC_BASE_EXT 16'hFFDE

// acceptance timing in machine cycles
`define MIAU_ACCEPT_MCYC 8
`define MIAU_MCYC_CLKS 4

// sequence states
`define MIAU_ST_IDLE 3'h0
`define MIAU_ST_PSW 3'h1
`define MIAU_ST_PCH 3'h2
`define MIAU_ST_PCL 3'h3
`define MIAU_ST_VEC 3'h4
`define MIAU_ST_WAIT 3'h5

`endif

// ---- hw/miau_accept_unit.v ----
/*
  maskable interrupt accept unit: request latches, per-source enables,
  global enable and the acceptance push/vector sequence.
  assumes a cpu sequencer on the same clock that flags instruction ends,
  reads stack/vector data it is handed, and signals return opcodes.
  limitation: register and vector layout is fixed for 24 sources.
*/
`timescale 1ns/10ps
`include "miau_defines.vh"

module miau_accept_unit #(
  parameter NUM_SRC = `MIAU_NUM_SRC,
  parameter NMI_LAST = 3,
  parameter ACCEPT_CLKS = `MIAU_ACCEPT_MCYC * `MIAU_MCYC_CLKS
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [NUM_SRC-1:0] irq_req_in,
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  output reg [7:0] sfr_rdata_out,
  input wire instr_last_in,
  input wire [15:0] pc_in,
  input wire [7:0] status_in,
  input wire [7:0] sp_in,
  input wire [15:0] vector_data_in,
  input wire ret_maskable_in,
  input wire ret_nonmaskable_in,
  input wire [7:0] pop_status_in,
  output wire irq_pending_out,
  output reg accept_busy_out,
  output reg push_we_out,
  output reg [7:0] push_addr_out,
  output reg [7:0] push_data_out,
  output reg [7:0] sp_load_out,
  output reg sp_we_out,
  output reg [15:0] vector_addr_out,
  output reg [15:0] pc_load_out,
  output reg pc_we_out,
  output reg [4:0] accepted_src_out
);

  // software-visible latches and enables, then sequencer and snapshot state
  reg [NUM_SRC-1:0] latch_q;
  reg [NUM_SRC-1:0] en_q;
  reg gie_q;
  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg [4:0] src_q;
  reg saved_gie_q;
  reg [15:0] saved_pc_q;
  reg [7:0] saved_status_q;
  reg [7:0] sp_q;

  // decode and selection signals
  wire [NUM_SRC-1:0] eligible;
  reg [4:0] win_src;
  reg win_valid;
  reg [NUM_SRC-1:0] wr_clear;
  reg [NUM_SRC-1:0] en_d;
  reg gie_wr_val;
  reg gie_wr;
  integer i;
  // one acceptance decision, shared by latch, enable and sequencer logic
  wire accept_take;
  // entry slot of the source being accepted
  wire [15:0] vec_base;
  wire [15:0] vec_slot;

  // enable mask; non-maskable sources bypass all enables, maskable ones
  // need both their own flag and the global enable, so a latch may sit
  // set and visible while its source is shut off
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_elig
      if (g <= NMI_LAST) begin : g_nmi
        assign eligible[g] = latch_q[g];
      end else begin : g_mask
        assign eligible[g] = latch_q[g] & en_q[g] & gie_q;
      end
    end
  endgenerate

  assign irq_pending_out = |eligible;

  // acceptance is decided only on an instruction's final cycle while idle;
  // a request latched mid-instruction waits for that cycle
  assign accept_take = (state_q == `MIAU_ST_IDLE) && instr_last_in && win_valid;

  // sources 16 and up live in a second, lower run of vector slots
  assign vec_base = (src_q >= 5'h10) ? `MIAU_VEC_BASE_EXT : `MIAU_VEC_BASE_LOW;
  assign vec_slot = vec_base - {10'h000, src_q, 1'b0};

  // fixed priority: lowest source number wins; the loop runs downwards so
  // the last eligible source seen is the lowest one
  always @* begin
    win_src = 5'h00;
    win_valid = 1'b0;
    for (i = NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (eligible[i]) begin
        win_src = i[4:0];
        win_valid = 1'b1;
      end
    end
  end

  // decode of software writes to latches and enables; a one written to a
  // latch bit decodes to no clear at all, so software never raises a request
  always @* begin
    wr_clear = {NUM_SRC{1'b0}};
    en_d = en_q;
    gie_wr = 1'b0;
    gie_wr_val = gie_q;
    if (sfr_wr_in) begin
      case (sfr_addr_in)
        // latch registers: zeros clear, ones are ignored
        `MIAU_ADDR_RL_LOW: wr_clear[7:0] = ~sfr_wdata_in;
        `MIAU_ADDR_RL_HIGH: wr_clear[15:8] = ~sfr_wdata_in;
        `MIAU_ADDR_RL_EXT: wr_clear[23:16] = ~sfr_wdata_in;
        // low enable register also carries the global enable in bit 0
        `MIAU_ADDR_EN_LOW: begin
          en_d[7:`MIAU_FIRST_MASKABLE] = sfr_wdata_in[7:`MIAU_FIRST_MASKABLE];
          gie_wr = 1'b1;
          gie_wr_val = sfr_wdata_in[`MIAU_GIE_BIT];
        end
        // remaining enable registers hold flags only
        `MIAU_ADDR_EN_HIGH: en_d[15:8] = sfr_wdata_in;
        `MIAU_ADDR_EN_EXT: en_d[23:16] = sfr_wdata_in;
        default: en_d = en_q;
      endcase
    end
  end

  // request latches, one flop per source: a new request beats a clear in
  // the same cycle, so a request landing on a software clear is not lost
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_latch
      // this source is the one taken at this edge
      wire take_here;
      assign take_here = accept_take && (win_src == g);
      always @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          latch_q[g] <= `MIAU_RL_BIT_RESET;
        end else if (irq_req_in[g]) begin
          latch_q[g] <= 1'b1;
        end else if (wr_clear[g]) begin
          latch_q[g] <= 1'b0;
        end else if (take_here) begin
          latch_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable flags and global enable; the acceptance clear wins over a
  // return or a software write on the same edge, so every handler starts
  // with maskable sources shut off
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= `MIAU_EN_RESET;
      gie_q <= 1'b0;
    end else begin
      // enables follow the decoded write
      en_q <= en_d;
      if (accept_take) begin
        gie_q <= 1'b0;
      end else if (ret_maskable_in || ret_nonmaskable_in) begin
        gie_q <= pop_status_in[`MIAU_GIE_BIT];
      end else if (gie_wr) begin
        gie_q <= gie_wr_val;
      end
    end
  end

  // acceptance sequencer: three push states, a vector load, then a wait
  // that pads the run out to eight machine cycles; cnt_q counts from the
  // first push state so the exit point moves with ACCEPT_CLKS alone
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= `MIAU_ST_IDLE;
      cnt_q <= 8'h00;
      src_q <= 5'h00;
      saved_gie_q <= 1'b0;
      saved_pc_q <= 16'h0000;
      saved_status_q <= 8'h00;
      sp_q <= 8'h00;
    end else begin
      case (state_q)
        // idle: snapshot cpu state at the instruction's final cycle
        `MIAU_ST_IDLE: begin
          cnt_q <= 8'h00;
          if (accept_take) begin
            state_q <= `MIAU_ST_PSW;
            src_q <= win_src;
            saved_gie_q <= gie_q;
            saved_pc_q <= pc_in;
            saved_status_q <= status_in;
            sp_q <= sp_in;
          end
        end
        // status word push
        `MIAU_ST_PSW: begin
          cnt_q <= cnt_q + 8'h01;
          state_q <= `MIAU_ST_PCH;
        end
        // pc high byte push
        `MIAU_ST_PCH: begin
          cnt_q <= cnt_q + 8'h01;
          state_q <= `MIAU_ST_PCL;
        end
        // pc low byte push
        `MIAU_ST_PCL: begin
          cnt_q <= cnt_q + 8'h01;
          state_q <= `MIAU_ST_VEC;
        end
        // entry address fetch from the vector slot
        `MIAU_ST_VEC: begin
          cnt_q <= cnt_q + 8'h01;
          state_q <= `MIAU_ST_WAIT;
        end
        // pad to the full acceptance length
        `MIAU_ST_WAIT: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q >= ACCEPT_CLKS - 2) begin
            state_q <= `MIAU_ST_IDLE;
          end
        end
        default: state_q <= `MIAU_ST_IDLE;
      endcase
    end
  end

  // stack, pc and vector strobes to the cpu: sp and pc strobes are one-cycle
  // pulses with data held until the next load, while push_we_out stays high
  // for the three push cycles with new push data each cycle, so pushes are sampled on the strobe
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accept_busy_out <= 1'b0;
      push_we_out <= 1'b0;
      push_addr_out <= 8'h00;
      push_data_out <= 8'h00;
      sp_load_out <= 8'h00;
      sp_we_out <= 1'b0;
      vector_addr_out <= 16'h0000;
      pc_load_out <= 16'h0000;
      pc_we_out <= 1'b0;
      accepted_src_out <= 5'h00;
    end else begin
      accept_busy_out <= (state_q != `MIAU_ST_IDLE) || accept_take;
      // strobes fall back to zero unless a state raises them
      push_we_out <= 1'b0;
      sp_we_out <= 1'b0;
      pc_we_out <= 1'b0;
      case (state_q)
        // status word first, at the current stack top
        `MIAU_ST_PSW: begin
          push_we_out <= 1'b1;
          push_addr_out <= sp_q;
          push_data_out <= {saved_status_q[7:1], saved_gie_q};
          vector_addr_out <= vec_slot;
          accepted_src_out <= src_q;
        end
        // then pc high, one below
        `MIAU_ST_PCH: begin
          push_we_out <= 1'b1;
          push_addr_out <= sp_q - 8'h01;
          push_data_out <= saved_pc_q[15:8];
        end
        // then pc low, with the stack pointer dropped by three
        `MIAU_ST_PCL: begin
          push_we_out <= 1'b1;
          push_addr_out <= sp_q - 8'h02;
          push_data_out <= saved_pc_q[7:0];
          sp_we_out <= 1'b1;
          sp_load_out <= sp_q - 8'h03;
        end
        // entry address becomes the new pc
        `MIAU_ST_VEC: begin
          pc_we_out <= 1'b1;
          pc_load_out <= vector_data_in;
        end
        // returns bump the stack pointer back by three
        `MIAU_ST_IDLE: begin
          if (ret_maskable_in || ret_nonmaskable_in) begin
            sp_we_out <= 1'b1;
            sp_load_out <= sp_in + 8'h03;
          end
        end
        default: push_we_out <= 1'b0;
      endcase
    end
  end

  // register readback: registered, so data stands from the cycle after
  // the strobe until the next read; unmapped addresses and the unstored
  // enable bits 3:1 read as zero
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      case (sfr_addr_in)
        // latch registers
        `MIAU_ADDR_RL_LOW: sfr_rdata_out <= latch_q[7:0];
        `MIAU_ADDR_RL_HIGH: sfr_rdata_out <= latch_q[15:8];
        `MIAU_ADDR_RL_EXT: sfr_rdata_out <= latch_q[23:16];
        // enable registers, global enable in bit 0 of the low one
        `MIAU_ADDR_EN_LOW: sfr_rdata_out <= {en_q[7:4], 3'h0, gie_q};
        `MIAU_ADDR_EN_HIGH: sfr_rdata_out <= en_q[15:8];
        `MIAU_ADDR_EN_EXT: sfr_rdata_out <= en_q[23:16];
        default: sfr_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule // miau_accept_unit

// ---- sim/miau_cpu_model.sv ----
/* cpu sequencer model: instruction ends, pc and sp tracking, vector table.
   assumes the accept unit's clock and reset and its registered strobes. */
`timescale 1ns/10ps
module miau_cpu_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire busy_in,
  input wire sp_we_in,
  input wire [7:0] sp_load_in,
  input wire pc_we_in,
  input wire [15:0] pc_load_in,
  input wire [15:0] vector_addr_in,
  output wire instr_last_out,
  output reg [15:0] pc_out,
  output reg [7:0] sp_out,
  output wire [15:0] vector_data_out
);
  reg [3:0] cnt_q;
  // twelve-clock instructions, halted while acceptance runs
  assign instr_last_out = (cnt_q == 4'hB) && !busy_in;
  // each vector slot holds the inverse of its address
  assign vector_data_out = ~vector_addr_in;
  // pc and sp follow the unit's loads
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      pc_out <= 16'h1000;
      sp_out <= 8'hF0;
    end else begin
      cnt_q <= (busy_in || instr_last_out) ? 4'h0 : cnt_q + 4'h1;
      pc_out <= pc_we_in ? pc_load_in : pc_out + {15'h0000, instr_last_out};
      if (sp_we_in) begin
        sp_out <= sp_load_in;
      end
    end
  end
endmodule // miau_cpu_model

// ---- sim/miau_accept_unit_chk.sv ----
/* checker: acceptance start and length, push order, vector slot, returns.
   assumes it is bound onto the accept unit top. */
`timescale 1ns/10ps
module miau_chk (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_rdata_out,
  input wire instr_last_in,
  input wire [7:0] sp_in,
  input wire ret_maskable_in,
  input wire ret_nonmaskable_in,
  input wire irq_pending_out,
  input wire accept_busy_out,
  input wire push_we_out,
  input wire [7:0] push_addr_out,
  input wire [7:0] sp_load_out,
  input wire sp_we_out,
  input wire [15:0] vector_addr_out,
  input wire [4:0] accepted_src_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // acceptance start, refusal and length
  a_take_at_last: assert property (instr_last_in && irq_pending_out && !accept_busy_out
    |=> accept_busy_out) else $error("pending request not taken");
  a_no_pending_take: assert property (instr_last_in && !irq_pending_out && !accept_busy_out
    |=> !accept_busy_out) else $error("acceptance without pending request");
  a_accept_length: assert property ($rose(accept_busy_out)
    |-> accept_busy_out [*8] ##1 accept_busy_out [*8] ##1 accept_busy_out [*8]
    ##1 accept_busy_out [*8] ##1 !accept_busy_out) else $error("acceptance length");
  // push order and stack pointer
  a_push_order: assert property (push_we_out && accept_busy_out && !$past(push_we_out)
    |=> (push_we_out && push_addr_out == $past(push_addr_out) - 8'h01)
    ##1 (push_we_out && push_addr_out == $past(push_addr_out) - 8'h01))
    else $error("push order");
  a_sp_minus_three: assert property (push_we_out && sp_we_out
    |-> sp_load_out == push_addr_out - 8'h01) else $error("stack pointer after push");
  a_vector_slot: assert property (accept_busy_out && $past(accept_busy_out)
    |-> vector_addr_out == ((accepted_src_out < 5'h10) ? 16'hFFFE : 16'hFFDE)
    - {10'h000, accepted_src_out, 1'b0})
    else $error("vector slot");
  a_return_sp: assert property ((ret_maskable_in || ret_nonmaskable_in) && !accept_busy_out
    |=> sp_we_out && sp_load_out == $past(sp_in) + 8'h03) else $error("return stack pointer");
  a_rdata_holds: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
    else $error("read data moved");
endmodule // miau_chk

bind miau_accept_unit miau_chk miau_chk_inst (.core_clk_in, .rst_n_in, .sfr_rd_in,
  .sfr_rdata_out, .instr_last_in, .sp_in, .ret_maskable_in, .ret_nonmaskable_in,
  .irq_pending_out, .accept_busy_out, .push_we_out, .push_addr_out, .sp_load_out,
  .sp_we_out, .vector_addr_out, .accepted_src_out);

// ---- sim/tb_miau_accept_unit.sv ----
/* bench for the accept unit: registers, masking, priority, returns.
   assumes the cpu model and the bound checker. */
`timescale 1ns/10ps
module tb_miau_accept_unit;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg [23:0] irq_req_in = 24'h000000;
  reg [7:0] sfr_addr_in = 8'h00;
  reg [7:0] sfr_wdata_in = 8'h00;
  reg sfr_wr_in = 1'b0;
  reg sfr_rd_in = 1'b0;
  reg ret_maskable_in = 1'b0;
  reg ret_nonmaskable_in = 1'b0;
  reg [7:0] pop_status_in = 8'h00;
  wire [7:0] status_in = 8'hA4;
  wire [15:0] pc_in, vector_data_in, vector_addr_out, pc_load_out;
  wire [7:0] sfr_rdata_out, push_addr_out, push_data_out, sp_load_out, sp_in;
  wire [4:0] accepted_src_out;
  wire instr_last_in, irq_pending_out, accept_busy_out, push_we_out, sp_we_out, pc_we_out;
  reg [7:0] rq [$];
  reg [20:0] aq [$];
  reg rd_d = 1'b0;
  reg pw_d = 1'b0;
  reg [4:0] s;
  integer mismatches = 0, tests_run = 0, cyc = 0, seed = 32, k;
  miau_accept_unit miau_accept_unit_inst (.core_clk_in, .rst_n_in, .irq_req_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .instr_last_in, .pc_in, .status_in,
    .sp_in, .vector_data_in, .ret_maskable_in, .ret_nonmaskable_in, .pop_status_in,
    .irq_pending_out, .accept_busy_out, .push_we_out, .push_addr_out, .push_data_out,
    .sp_load_out, .sp_we_out, .vector_addr_out, .pc_load_out, .pc_we_out, .accepted_src_out);
  miau_cpu_model miau_cpu_model_inst (.clk_in(core_clk_in), .rst_n_in,
    .busy_in(accept_busy_out), .sp_we_in(sp_we_out), .sp_load_in(sp_load_out),
    .pc_we_in(pc_we_out), .pc_load_in(pc_load_out), .vector_addr_in(vector_addr_out),
    .instr_last_out(instr_last_in), .pc_out(pc_in), .sp_out(sp_in),
    .vector_data_out(vector_data_in));
  // 40 MHz clock
  always #12.5 core_clk_in = ~core_clk_in;
  // address of a source's latch or enable register
  function [7:0] fa(input [4:0] x, input e);
    fa = (x < 5'd8) ? (e ? 8'h3A : 8'h3C) : (x < 5'd16) ? (e ? 8'h3B : 8'h3D) : (e ? 8'h2C : 8'h2E);
  endfunction
  // expected source and entry address
  function [20:0] xa(input [4:0] x);
    xa = {x, ~(((x < 5'd16) ? 16'hFFFE : 16'hFFDE) - {10'h000, x, 1'b0})};
  endfunction
  task chk(input [63:0] nm, input [20:0] e, input [20:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge core_clk_in);
      sfr_wr_in <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge core_clk_in);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      rq.push_back(e);
      @(posedge core_clk_in);
      sfr_rd_in <= 1'b0;
    end
  endtask
  task req(input [4:0] x);
    begin
      @(posedge core_clk_in);
      irq_req_in <= 24'h000001 << x;
      @(posedge core_clk_in);
      irq_req_in <= 24'h000000;
      repeat (60) @(posedge core_clk_in);
    end
  endtask
  task ret(input m, input [7:0] p);
    begin
      @(posedge core_clk_in);
      ret_maskable_in <= m;
      ret_nonmaskable_in <= !m;
      pop_status_in <= p;
      @(posedge core_clk_in);
      ret_maskable_in <= 1'b0;
      ret_nonmaskable_in <= 1'b0;
      repeat (60) @(posedge core_clk_in);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // result watcher and cycle ceiling
  always @(posedge core_clk_in) begin
    rd_d <= sfr_rd_in;
    pw_d <= push_we_out;
    cyc <= cyc + 1;
    if (push_we_out && !pw_d)
      chk("status", {13'h0000, 8'hA4 & 8'hFE}, {13'h0000, push_data_out & 8'hFE});
    if (rd_d) chk("rdata", rq.pop_front(), sfr_rdata_out);
    if (pc_we_out && accept_busy_out) chk("accept", aq.size() ? aq.pop_front() : 21'h1FFFFF,
      {accepted_src_out, pc_load_out});
    if (cyc == 6000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (k = 0; k < 6; k = k + 1) rd(fa({k[2:1], 3'b000}, k[0]), 8'h00);
    wr(8'h3A, 8'h01);
    req(5'd5);
    rd(8'h3C, 8'h20);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h20);
    wr(8'h3C, 8'hDF);
    rd(8'h3C, 8'h00);
    wr(8'h3A, 8'h00);
    req(5'd6);
    req(5'd9);
    wr(8'h3A, 8'h40);
    wr(8'h3B, 8'h02);
    repeat (40) @(posedge core_clk_in);
    rd(8'h3D, 8'h02);
    aq.push_back(xa(5'd6));
    wr(8'h3A, 8'h41);
    repeat (60) @(posedge core_clk_in);
    rd(8'h3C, 8'h00);
    rd(8'h3A, 8'h40);
    aq.push_back(xa(5'd9));
    ret(1'b1, 8'h01);
    rd(8'h3D, 8'h00);
    aq.push_back(xa(5'd2));
    req(5'd2);
    ret(1'b0, 8'h00);
    for (k = 0; k < 4; k = k + 1) begin
      s = 5'd4 + ($unsigned($random(seed)) % 20);
      wr(fa(s, 1'b1), 8'h01 << s[2:0]);
      req(s);
      aq.push_back(xa(s));
      wr(8'h3A, (s < 5'd8) ? (8'h01 << s[2:0]) | 8'h01 : 8'h01);
      repeat (60) @(posedge core_clk_in);
      rd(fa(s, 1'b0), 8'h00);
      wr(fa(s, 1'b1), 8'h00);
    end
    chk("left", 21'h000000, aq.size());
    end_sim;
  end
endmodule // tb_miau_accept_unit
